// ### core/mci_map.vh
`ifndef MCI_MAP_VH
`define MCI_MAP_VH
// Clock and wait tick timing.
`define MCI_CLK_NS 5
`define MCI_TICK_NS 10000000
// Command numbers.
`define MCI_C_SPIN_POS 8'h01
`define MCI_C_SPIN_NEG 8'h02
`define MCI_C_HALT 8'h03
`define MCI_C_MOVE 8'h04
`define MCI_C_AP_WR 8'h05
`define MCI_C_AP_RD 8'h06
`define MCI_C_GP_WR 8'h09
`define MCI_C_GP_RD 8'h0a
`define MCI_C_GP_PERSIST 8'h0b
`define MCI_C_GP_RELOAD 8'h0c
`define MCI_C_OUT_WR 8'h0e
`define MCI_C_IN_RD 8'h0f
`define MCI_C_ARITH_K 8'h13
`define MCI_C_COMPARE 8'h14
`define MCI_C_JUMP_IF 8'h15
`define MCI_C_JUMP 8'h16
`define MCI_C_CALL 8'h17
`define MCI_C_RETURN 8'h18
`define MCI_C_IRQ_UNMASK 8'h19
`define MCI_C_IRQ_MASK 8'h1a
`define MCI_C_WAIT 8'h1b
`define MCI_C_STOP 8'h1c
`define MCI_C_CO_STORE 8'h1e
`define MCI_C_CO_READ 8'h1f
`define MCI_C_CO_CAPTURE 8'h20
`define MCI_C_ARITH_X 8'h21
`define MCI_C_ACC_TO_AP 8'h22
`define MCI_C_ACC_TO_GP 8'h23
`define MCI_C_IRQ_BIND 8'h25
`define MCI_C_IRQ_RETURN 8'h26
`define MCI_C_ACC_TO_CO 8'h27
// Interrupt numbers and implemented sources.
`define MCI_IRQ_GLOBAL 8'hff
`define MCI_IRQ_COUNT 8'h2b
`define MCI_IRQ_VALID 43'h781f8e3803f
`define MCI_IRQ_CFG_BANK 8'h03
// Arithmetic operation codes; 8 loads X from the accumulator.
`define MCI_OP_XLOAD 4'h8
// Register offsets and control fields.
`define MCI_R_CTRL 8'h00
`define MCI_R_STATUS 8'h04
`define MCI_R_ACCU 8'h08
`define MCI_R_XREG 8'h0c
`define MCI_R_PC 8'h10
`define MCI_R_PEND 8'h14
`define MCI_CTRL_RUN 0
`define MCI_CTRL_RESTART 1
`endif

// ### core/mci_core.v
// Behaviour
// - decode motion commands 1-4, 30-32, both modes
// - decode parameter commands 5,6,9-12, both modes
// - axis parameters per axis, module parameters once
// - flow commands 20-24,27,28 for programs only
// - command 14 sets output, 15 reads input
// - command 19 combines accumulator with constant
// - command 33 combines accumulator with X
// - commands 34,35,39 copy accumulator out
// - program value reads load the accumulator
// - X register loadable from the accumulator
// - host value reads leave accumulator untouched
// - decode interrupt commands 25,26,37,38
// - timers 0-2, target reached 3-5
// - stall 15-17, deviation 21-23
// - limits 27-32 left/right, inputs 39-42
// - number 255 is the global switch
// - dispatch needs enable and bound vector
// - save accumulator, X and flags on entry
// - no nesting while a handler runs
// - irq_return restores context and resumes
// - bank 3 module parameters are plain storage; interrupts ignore them
`timescale 1ns/1ps
`include "mci_map.vh"
module mci_core #(
  parameter [31:0] TICK_CYC = `MCI_TICK_NS / `MCI_CLK_NS
) (
  input wire clk,
  input wire rst,
  input wire host_valid,
  input wire [7:0] host_num,
  input wire [7:0] host_type,
  input wire [7:0] host_bank,
  input wire [31:0] host_value,
  output reg rsp_valid_ff,
  output reg rsp_ok_ff,
  output reg [31:0] rsp_value_ff,
  output reg [7:0] prog_addr_ff,
  input wire [7:0] prog_num,
  input wire [7:0] prog_type,
  input wire [7:0] prog_bank,
  input wire [31:0] prog_value,
  input wire [42:0] irq_evt,
  input wire [95:0] act_pos,
  input wire [3:0] io_in,
  output reg [3:0] io_out_ff,
  output reg mot_stb_ff,
  output reg [7:0] mot_op_ff,
  output reg [1:0] mot_axis_ff,
  output reg [31:0] mot_val_ff,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [31:0] reg_rdata_ff
);

  // Storage: axis parameters are kept per axis, module ones once.
  reg [31:0] ap_mem [0:63];
  reg [31:0] gp_mem [0:255];
  reg [31:0] nv_mem [0:255];
  reg [31:0] co_mem [0:127];
  reg [7:0] vec_mem [0:42];
  reg [7:0] stk_mem [0:3];

  reg run_ff, wait_ff, inirq_ff, gie_ff, z_ff, gt_ff;
  reg [31:0] accu_ff, x_ff, wcnt_ff, tcnt_ff;
  reg [31:0] sav_accu_ff, sav_x_ff;
  reg [7:0] sav_pc_ff;
  reg sav_z_ff, sav_gt_ff;
  reg [2:0] sp_ff;
  reg [42:0] pend_ff, ien_ff, vval_ff;
  reg [3:0] in_s1_ff, in_s2_ff;
  reg tick_ff;

  // The host wins the decoder; a program simply stalls for that cycle.
  wire use_host = host_valid;
  wire [7:0] c_num = use_host ? host_num : prog_num;
  wire [7:0] c_type = use_host ? host_type : prog_type;
  wire [7:0] c_bank = use_host ? host_bank : prog_bank;
  wire [31:0] c_value = use_host ? host_value : prog_value;
  wire [1:0] ax = c_bank[1:0];
  wire axok = (c_bank < 8'h03);
  wire [5:0] ap_idx = {ax, c_type[3:0]};
  wire apok = axok & (c_type < 8'h10);
  wire [7:0] gp_idx = {c_bank[1:0], c_type[5:0]};
  wire gpok = (c_bank < 8'h04) & (c_type < 8'h40);
  wire [6:0] co_idx = {ax, c_type[4:0]};
  wire cook = axok & (c_type < 8'h20);
  wire [5:0] irq_idx = c_type[5:0];
  // Numbers without a source are refused, so no enable or vector is
  // ever stored for an event that can never arrive.
  wire [42:0] irq_src = `MCI_IRQ_VALID;
  wire irqok = (c_type < `MCI_IRQ_COUNT) && irq_src[irq_idx];

  // Candidates need an event, an enable and a bound vector.
  wire [42:0] cand = pend_ff & ien_ff & vval_ff;
  wire disp = run_ff & gie_ff & ~inirq_ff & (|cand) & ~use_host;
  wire go_prog = run_ff & ~wait_ff & ~use_host & ~disp;
  wire c_vld = use_host | go_prog;

  // Lowest pending number wins when several are ready at once.
  reg [5:0] irq_n;
  integer i;
  always @* begin
    irq_n = 6'h00;
    for (i = 42; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        irq_n = i[5:0];
      end
    end
  end

  // Arithmetic: 0 add, 1 sub, 2 mul, 3 and, 4 or, 5 xor, 6 not, 7 load.
  function [31:0] mci_alu;
    input [3:0] op;
    input [31:0] a;
    input [31:0] b;
    reg [63:0] p;
    begin
      p = a * b;
      case (op)
        4'h0: mci_alu = a + b;
        4'h1: mci_alu = a - b;
        4'h2: mci_alu = p[31:0];
        4'h3: mci_alu = a & b;
        4'h4: mci_alu = a | b;
        4'h5: mci_alu = a ^ b;
        4'h6: mci_alu = ~a;
        default: mci_alu = b;
      endcase
    end
  endfunction

  // Decode: acceptance, returned value and jump condition.
  reg ok, ret, jc;
  reg [31:0] rv;
  always @* begin
    ok = 1'b0;
    ret = 1'b0;
    rv = 32'h0000_0000;
    case (c_type[2:0])
      3'h0, 3'h2: jc = z_ff;
      3'h1, 3'h3: jc = ~z_ff;
      3'h4: jc = gt_ff;
      3'h5: jc = gt_ff | z_ff;
      3'h6: jc = ~gt_ff & ~z_ff;
      default: jc = ~gt_ff;
    endcase
    case (c_num)
      `MCI_C_SPIN_POS, `MCI_C_SPIN_NEG, `MCI_C_HALT: ok = axok;
      `MCI_C_MOVE: ok = axok & ((c_type < 8'h02) | cook);
      `MCI_C_CO_STORE, `MCI_C_CO_CAPTURE: ok = cook;
      `MCI_C_CO_READ: begin
        ok = cook;
        ret = 1'b1;
        rv = co_mem[co_idx];
      end
      `MCI_C_AP_WR, `MCI_C_ACC_TO_AP: ok = apok;
      `MCI_C_AP_RD: begin
        ok = apok;
        ret = 1'b1;
        rv = ap_mem[ap_idx];
      end
      `MCI_C_GP_WR, `MCI_C_ACC_TO_GP: ok = gpok;
      `MCI_C_GP_PERSIST, `MCI_C_GP_RELOAD: ok = gpok;
      `MCI_C_GP_RD: begin
        ok = gpok;
        ret = 1'b1;
        rv = gp_mem[gp_idx];
      end
      `MCI_C_ACC_TO_CO: ok = cook;
      `MCI_C_OUT_WR: ok = (c_type < 8'h04);
      `MCI_C_IN_RD: begin
        ok = (c_type < 8'h04);
        ret = 1'b1;
        rv = {31'h0000_0000, in_s2_ff[c_type[1:0]]};
      end
      `MCI_C_ARITH_K: ok = (c_type < 8'h08);
      `MCI_C_ARITH_X: ok = (c_type < 8'h09);
      `MCI_C_COMPARE, `MCI_C_JUMP_IF, `MCI_C_JUMP: ok = ~use_host;
      `MCI_C_WAIT, `MCI_C_STOP: ok = ~use_host;
      `MCI_C_CALL: ok = ~use_host & (sp_ff < 3'h4);
      `MCI_C_RETURN: ok = ~use_host & (sp_ff != 3'h0);
      `MCI_C_IRQ_UNMASK, `MCI_C_IRQ_MASK: begin
        ok = irqok | (c_type == `MCI_IRQ_GLOBAL);
      end
      `MCI_C_IRQ_BIND: ok = irqok;
      `MCI_C_IRQ_RETURN: ok = ~use_host & inirq_ff;
      default: ok = 1'b0;
    endcase
  end

  // Pins are synchronised twice; the tick divider paces waits.
  always @(posedge clk) begin
    if (rst) begin
      in_s1_ff <= 4'h0;
      in_s2_ff <= 4'h0;
      tcnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      in_s1_ff <= io_in;
      in_s2_ff <= in_s1_ff;
      tick_ff <= (tcnt_ff == TICK_CYC - 32'h0000_0001);
      if (tcnt_ff == TICK_CYC - 32'h0000_0001) begin
        tcnt_ff <= 32'h0000_0000;
      end else begin
        tcnt_ff <= tcnt_ff + 32'h0000_0001;
      end
    end
  end

  // Register read port; data stand for exactly one cycle.
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_re) begin
      case (reg_addr)
        `MCI_R_CTRL: reg_rdata_ff <= {31'h0000_0000, run_ff};
        `MCI_R_STATUS: reg_rdata_ff <= {27'h0, gt_ff, z_ff, gie_ff,
          inirq_ff, wait_ff};
        `MCI_R_ACCU: reg_rdata_ff <= accu_ff;
        `MCI_R_XREG: reg_rdata_ff <= x_ff;
        `MCI_R_PC: reg_rdata_ff <= {24'h00_0000, prog_addr_ff};
        `MCI_R_PEND: reg_rdata_ff <= pend_ff[31:0];
        default: reg_rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

  // Main sequencer. Later assignments win, so an event that lands on
  // the cycle its pending bit is taken is re-latched, never lost.
  always @(posedge clk) begin
    if (rst) begin
      run_ff <= 1'b0;
      wait_ff <= 1'b0;
      wcnt_ff <= 32'h0000_0000;
      inirq_ff <= 1'b0;
      gie_ff <= 1'b0;
      z_ff <= 1'b0;
      gt_ff <= 1'b0;
      accu_ff <= 32'h0000_0000;
      x_ff <= 32'h0000_0000;
      sav_accu_ff <= 32'h0000_0000;
      sav_x_ff <= 32'h0000_0000;
      sav_pc_ff <= 8'h00;
      sav_z_ff <= 1'b0;
      sav_gt_ff <= 1'b0;
      sp_ff <= 3'h0;
      pend_ff <= 43'h0;
      ien_ff <= 43'h0;
      vval_ff <= 43'h0;
      prog_addr_ff <= 8'h00;
      rsp_valid_ff <= 1'b0;
      rsp_ok_ff <= 1'b0;
      rsp_value_ff <= 32'h0000_0000;
      io_out_ff <= 4'h0;
      mot_stb_ff <= 1'b0;
      mot_op_ff <= 8'h00;
      mot_axis_ff <= 2'h0;
      mot_val_ff <= 32'h0000_0000;
    end else begin
      rsp_valid_ff <= use_host;
      rsp_ok_ff <= use_host & ok;
      rsp_value_ff <= (use_host & ok) ? rv : 32'h0000_0000;
      mot_stb_ff <= 1'b0;
      if (wait_ff & tick_ff) begin
        wcnt_ff <= wcnt_ff - 32'h0000_0001;
        wait_ff <= (wcnt_ff > 32'h0000_0001);
      end
      if (reg_we && reg_addr == `MCI_R_CTRL) begin
        run_ff <= reg_wdata[`MCI_CTRL_RUN];
        if (reg_wdata[`MCI_CTRL_RESTART]) begin
          prog_addr_ff <= 8'h00;
          sp_ff <= 3'h0;
          inirq_ff <= 1'b0;
          wait_ff <= 1'b0;
        end
      end
      if (disp) begin
        sav_accu_ff <= accu_ff;
        sav_x_ff <= x_ff;
        sav_z_ff <= z_ff;
        sav_gt_ff <= gt_ff;
        sav_pc_ff <= prog_addr_ff;
        prog_addr_ff <= vec_mem[irq_n];
        inirq_ff <= 1'b1;
        pend_ff[irq_n] <= 1'b0;
      end else if (c_vld) begin
        if (go_prog) begin
          prog_addr_ff <= prog_addr_ff + 8'h01;
        end
        if (ok) begin
          // Reads land in the accumulator only for the program.
          if (ret & ~use_host) begin
            accu_ff <= rv;
          end
          case (c_num)
            `MCI_C_SPIN_POS, `MCI_C_SPIN_NEG, `MCI_C_HALT,
            `MCI_C_MOVE: begin
              mot_stb_ff <= 1'b1;
              mot_op_ff <= c_num;
              mot_axis_ff <= ax;
              if (c_num == `MCI_C_MOVE && c_type == 8'h02) begin
                mot_val_ff <= co_mem[co_idx];
              end else begin
                mot_val_ff <= c_value;
              end
            end
            `MCI_C_CO_STORE: co_mem[co_idx] <= c_value;
            `MCI_C_CO_CAPTURE: co_mem[co_idx] <= act_pos[ax*32 +: 32];
            `MCI_C_AP_WR: ap_mem[ap_idx] <= c_value;
            `MCI_C_GP_WR: gp_mem[gp_idx] <= c_value;
            `MCI_C_GP_PERSIST: nv_mem[gp_idx] <= gp_mem[gp_idx];
            `MCI_C_GP_RELOAD: gp_mem[gp_idx] <= nv_mem[gp_idx];
            `MCI_C_OUT_WR: io_out_ff[c_type[1:0]] <= c_value[0];
            `MCI_C_ARITH_K: begin
              accu_ff <= mci_alu(c_type[3:0], accu_ff, c_value);
            end
            `MCI_C_ARITH_X: begin
              if (c_type[3:0] == `MCI_OP_XLOAD) begin
                x_ff <= accu_ff;
              end else begin
                accu_ff <= mci_alu(c_type[3:0], accu_ff, x_ff);
              end
            end
            `MCI_C_ACC_TO_AP: ap_mem[ap_idx] <= accu_ff;
            `MCI_C_ACC_TO_GP: gp_mem[gp_idx] <= accu_ff;
            `MCI_C_ACC_TO_CO: co_mem[co_idx] <= accu_ff;
            `MCI_C_COMPARE: begin
              z_ff <= (accu_ff == c_value);
              gt_ff <= ($signed(accu_ff) > $signed(c_value));
            end
            `MCI_C_JUMP: prog_addr_ff <= c_value[7:0];
            `MCI_C_JUMP_IF: begin
              if (jc) begin
                prog_addr_ff <= c_value[7:0];
              end
            end
            `MCI_C_CALL: begin
              stk_mem[sp_ff[1:0]] <= prog_addr_ff + 8'h01;
              sp_ff <= sp_ff + 3'h1;
              prog_addr_ff <= c_value[7:0];
            end
            `MCI_C_RETURN: begin
              prog_addr_ff <= stk_mem[sp_ff[1:0] - 2'h1];
              sp_ff <= sp_ff - 3'h1;
            end
            `MCI_C_WAIT: begin
              wcnt_ff <= c_value;
              wait_ff <= (c_type == 8'h00) && (c_value != 32'h0000_0000);
            end
            `MCI_C_STOP: run_ff <= 1'b0;
            `MCI_C_IRQ_UNMASK: begin
              if (c_type == `MCI_IRQ_GLOBAL) begin
                gie_ff <= 1'b1;
              end else begin
                ien_ff[irq_idx] <= 1'b1;
              end
            end
            `MCI_C_IRQ_MASK: begin
              if (c_type == `MCI_IRQ_GLOBAL) begin
                gie_ff <= 1'b0;
              end else begin
                ien_ff[irq_idx] <= 1'b0;
              end
            end
            `MCI_C_IRQ_BIND: begin
              vec_mem[irq_idx] <= c_value[7:0];
              vval_ff[irq_idx] <= 1'b1;
            end
            `MCI_C_IRQ_RETURN: begin
              accu_ff <= sav_accu_ff;
              x_ff <= sav_x_ff;
              z_ff <= sav_z_ff;
              gt_ff <= sav_gt_ff;
              prog_addr_ff <= sav_pc_ff;
              inirq_ff <= 1'b0;
            end
            default: ;
          endcase
        end
      end
      // Only implemented sources latch; they stay pending meanwhile.
      pend_ff <= (disp ? (pend_ff & ~(43'h1 << irq_n)) : pend_ff)
        | (irq_evt & `MCI_IRQ_VALID);
    end
  end

endmodule

// ### dv/mci_core_asserts.sv
`timescale 1ns/1ps
// Watches the host command port and the outputs that commands drive.
module mci_core_asserts #(
  parameter [31:0] TICK_CYC = 32'h4
) (
  input logic clk,
  input logic rst,
  input logic host_valid,
  input logic [7:0] host_num,
  input logic [7:0] host_type,
  input logic [7:0] host_bank,
  input logic [31:0] host_value,
  input logic rsp_valid_ff,
  input logic rsp_ok_ff,
  input logic [31:0] rsp_value_ff,
  input logic [3:0] io_out_ff,
  input logic mot_stb_ff,
  input logic [7:0] mot_op_ff,
  input logic [1:0] mot_axis_ff
);
  // All checks share one clock, and reset voids them.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_rsp_next: assert property (host_valid |-> ##1 rsp_valid_ff)
    else $error("host command left without an answer");
  chk_rsp_cause: assert property (rsp_valid_ff |-> $past(host_valid))
    else $error("answer without a host command");
  chk_flow_host: assert property (
    host_valid && host_num inside {[8'h14:8'h18], 8'h1b, 8'h1c, 8'h26}
    |=> rsp_valid_ff && !rsp_ok_ff)
    else $error("flow command accepted from the host");
  chk_unknown_cmd: assert property (
    host_valid && host_num inside {8'h00, 8'h07, 8'h08, 8'h0d,
    [8'h10:8'h12], 8'h1d, 8'h24, [8'h28:8'hff]} |=> !rsp_ok_ff)
    else $error("undecoded command accepted");
  chk_reject_zero: assert property (
    rsp_valid_ff && !rsp_ok_ff |-> rsp_value_ff == 32'h0)
    else $error("refused command returned a value");
  chk_motion_issue: assert property (
    host_valid && host_num inside {[8'h01:8'h03]} && host_bank < 8'h03
    |=> mot_stb_ff && rsp_ok_ff && mot_op_ff == $past(host_num)
    && {6'h0, mot_axis_ff} == $past(host_bank))
    else $error("motion command not passed to the axis");
  chk_output_set: assert property (
    host_valid && host_num == 8'h0e && host_type < 8'h04
    |=> rsp_ok_ff && {31'h0, io_out_ff[$past(host_type)]}
    == ($past(host_value) & 32'h1))
    else $error("output pin not set as commanded");
  chk_param_ok: assert property (
    host_valid && host_num inside {8'h05, 8'h06} && host_type < 8'h10
    && host_bank < 8'h03 |=> rsp_ok_ff)
    else $error("axis parameter access refused");
  chk_global_irq: assert property (
    host_valid && host_num inside {8'h19, 8'h1a} && host_type == 8'hff
    |=> rsp_ok_ff)
    else $error("global interrupt switch refused");
  chk_irq_absent: assert property (
    host_valid && host_num == 8'h19 && host_type inside {[8'h06:8'h0e],
    [8'h12:8'h14], [8'h18:8'h1a], [8'h21:8'h26], [8'h2b:8'hfe]}
    |=> !rsp_ok_ff)
    else $error("interrupt number without a source accepted");
  chk_irq_source: assert property (
    host_valid && host_num == 8'h1a && host_type inside {[8'h00:8'h05],
    [8'h0f:8'h11], [8'h15:8'h17], [8'h1b:8'h20], [8'h27:8'h2a]}
    |=> rsp_ok_ff)
    else $error("interrupt source number refused");
endmodule

bind mci_core mci_core_asserts #(.TICK_CYC(TICK_CYC)) u_mci_core_asserts (
  .clk(clk), .rst(rst), .host_valid(host_valid), .host_num(host_num),
  .host_type(host_type), .host_bank(host_bank), .host_value(host_value),
  .rsp_valid_ff(rsp_valid_ff), .rsp_ok_ff(rsp_ok_ff),
  .rsp_value_ff(rsp_value_ff), .io_out_ff(io_out_ff),
  .mot_stb_ff(mot_stb_ff), .mot_op_ff(mot_op_ff), .mot_axis_ff(mot_axis_ff)
);

// ### dv/mci_prog_store.sv
`timescale 1ns/1ps
// Program store: answers the current program address in the same cycle.
module mci_prog_store (
  input logic [7:0] addr,
  output logic [7:0] num,
  output logic [7:0] typ,
  output logic [7:0] bank,
  output logic [31:0] value
);
  logic [55:0] mem [0:255];

  // Empty slots hold stop, so a runaway program halts.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {8'h1c, 48'h0};
    end
    mem[0] = {8'h25, 8'h00, 8'h00, 32'ha};
    mem[1] = {8'h19, 8'h00, 8'h00, 32'h0};
    mem[2] = {8'h19, 8'hff, 8'h00, 32'h0};
    mem[3] = {8'h13, 8'h07, 8'h00, 32'h11};
    mem[4] = {8'h16, 8'h00, 8'h00, 32'h4};
    // Handler counts its runs in module parameter 9.
    mem[10] = {8'h0a, 8'h09, 8'h00, 32'h0};
    mem[11] = {8'h13, 8'h00, 8'h00, 32'h1};
    mem[12] = {8'h23, 8'h09, 8'h00, 32'h0};
    mem[13] = {8'h26, 8'h00, 8'h00, 32'h0};
  end

  assign {num, typ, bank, value} = mem[addr];
endmodule

// ### dv/mci_core_test.sv
`timescale 1ns/1ps
module mci_core_test;
  typedef struct {
    logic [7:0] n;
    logic [7:0] t;
    logic [7:0] b;
    logic [31:0] v;
    logic ok;
    logic [31:0] r;
  } mci_row_t;
  logic clk, rst, host_valid, rsp_valid_ff, rsp_ok_ff, mot_stb_ff;
  logic reg_we, reg_re, rok;
  logic [7:0] host_num, host_type, host_bank, prog_addr_ff, prog_num;
  logic [7:0] prog_type, prog_bank, mot_op_ff, reg_addr;
  logic [31:0] host_value, rsp_value_ff, prog_value, mot_val_ff;
  logic [31:0] reg_wdata, reg_rdata_ff, rv;
  logic [42:0] irq_evt;
  logic [95:0] act_pos;
  logic [3:0] io_in, io_out_ff;
  logic [1:0] mot_axis_ff;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] bad [0:11] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1b,
    8'h1c, 8'h26, 8'h00, 8'h07, 8'h24, 8'h28};
  mci_row_t rows [0:23] = '{
    '{8'h01, 8'h00, 8'h00, 32'h64, 1'b1, 32'h0},
    '{8'h02, 8'h00, 8'h02, 32'h64, 1'b1, 32'h0},
    '{8'h03, 8'h00, 8'h01, 32'h0, 1'b1, 32'h0},
    '{8'h04, 8'h00, 8'h00, 32'h1f4, 1'b1, 32'h0},
    '{8'h01, 8'h00, 8'h03, 32'h0, 1'b0, 32'h0},
    '{8'h05, 8'h04, 8'h00, 32'h99, 1'b1, 32'h0},
    '{8'h05, 8'h04, 8'h01, 32'h1234, 1'b1, 32'h0},
    '{8'h06, 8'h04, 8'h01, 32'h0, 1'b1, 32'h1234},
    '{8'h06, 8'h04, 8'h00, 32'h0, 1'b1, 32'h99},
    '{8'h09, 8'h07, 8'h00, 32'h55, 1'b1, 32'h0},
    '{8'h0b, 8'h07, 8'h00, 32'h0, 1'b1, 32'h0},
    '{8'h09, 8'h07, 8'h00, 32'h66, 1'b1, 32'h0},
    '{8'h0c, 8'h07, 8'h00, 32'h0, 1'b1, 32'h0},
    '{8'h0a, 8'h07, 8'h00, 32'h0, 1'b1, 32'h55},
    '{8'h1e, 8'h05, 8'h00, 32'h77, 1'b1, 32'h0},
    '{8'h1f, 8'h05, 8'h00, 32'h0, 1'b1, 32'h77},
    '{8'h20, 8'h06, 8'h01, 32'h0, 1'b1, 32'h0},
    '{8'h1f, 8'h06, 8'h01, 32'h0, 1'b1, 32'h2222},
    '{8'h0e, 8'h02, 8'h00, 32'h1, 1'b1, 32'h0},
    '{8'h0f, 8'h01, 8'h00, 32'h0, 1'b1, 32'h1},
    '{8'h19, 8'h06, 8'h00, 32'h0, 1'b0, 32'h0},
    '{8'h1a, 8'h0f, 8'h00, 32'h0, 1'b1, 32'h0},
    '{8'h09, 8'h00, 8'h03, 32'h3e8, 1'b1, 32'h0},
    '{8'h09, 8'h09, 8'h00, 32'h0, 1'b1, 32'h0}};

  // A short tick keeps wait commands brief in simulation.
  mci_core #(.TICK_CYC(32'h4)) u_mci_core (
    .clk(clk), .rst(rst), .host_valid(host_valid), .host_num(host_num),
    .host_type(host_type), .host_bank(host_bank), .host_value(host_value),
    .rsp_valid_ff(rsp_valid_ff), .rsp_ok_ff(rsp_ok_ff),
    .rsp_value_ff(rsp_value_ff), .prog_addr_ff(prog_addr_ff),
    .prog_num(prog_num), .prog_type(prog_type), .prog_bank(prog_bank),
    .prog_value(prog_value), .irq_evt(irq_evt), .act_pos(act_pos),
    .io_in(io_in), .io_out_ff(io_out_ff), .mot_stb_ff(mot_stb_ff),
    .mot_op_ff(mot_op_ff), .mot_axis_ff(mot_axis_ff),
    .mot_val_ff(mot_val_ff), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_ff(reg_rdata_ff));

  mci_prog_store u_mci_prog_store (.addr(prog_addr_ff), .num(prog_num),
    .typ(prog_type), .bank(prog_bank), .value(prog_value));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cmp32(input string w, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One host command; the answer is taken one edge after the request.
  task automatic host(input logic [7:0] n, t, b, input logic [31:0] v);
    @(posedge clk);
    host_valid <= 1'b1;
    {host_num, host_type, host_bank, host_value} <= {n, t, b, v};
    @(posedge clk);
    host_valid <= 1'b0;
    #1;
    cmp32("rsp_valid", 32'h1, {31'h0, rsp_valid_ff});
    rok = rsp_ok_ff;
    rv = rsp_value_ff;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_we, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    {reg_re, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata_ff;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    cmp32("register", e, d);
  endtask

  // Polls a register, or a module parameter over the host port, with a bound.
  task automatic poll(input bit h, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    for (int i = 0; i < 40; i++) begin
      if (h) begin
        host(8'h0a, a, 8'h00, 32'h0);
        d = rv;
      end else begin
        rd(a, d);
      end
      if (d === e) return;
    end
    failures++;
    $display("unexpected poll %h: expected %h seen %h", a, e, d);
    end_of_test();
  endtask

  // Main sequence: reset, command table, accumulator work, interrupts.
  initial begin
    rst = 1'b1;
    {host_valid, reg_we, reg_re} = 3'h0;
    {host_num, host_type, host_bank, host_value} = 56'h0;
    {reg_addr, reg_wdata, irq_evt} = 83'h0;
    act_pos = {32'h3, 32'h2222, 32'h1};
    io_in = 4'h2;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp32("outputs", 32'h0, {rsp_valid_ff, mot_stb_ff, io_out_ff});
    rdc(8'h08, 32'h0);
    rdc(8'h00, 32'h0);
    rdc(8'h40, 32'h0);
    wr(8'h08, 32'h5);
    rdc(8'h08, 32'h0);
    foreach (rows[i]) begin
      host(rows[i].n, rows[i].t, rows[i].b, rows[i].v);
      cmp32("rsp_ok", {31'h0, rows[i].ok}, {31'h0, rok});
      cmp32("rsp_value", rows[i].r, rv);
    end
    cmp32("io_out", 32'h4, {28'h0, io_out_ff});
    cmp32("mot_val", 32'h1f4, mot_val_ff);
    host(8'h13, 8'h07, 8'h00, 32'h10);
    host(8'h13, 8'h00, 8'h00, 32'h5);
    rdc(8'h08, 32'h15);
    host(8'h21, 8'h08, 8'h00, 32'h0);
    rdc(8'h0c, 32'h15);
    host(8'h21, 8'h00, 8'h00, 32'h0);
    rdc(8'h08, 32'h2a);
    host(8'h22, 8'h03, 8'h02, 32'h0);
    host(8'h06, 8'h03, 8'h02, 32'h0);
    cmp32("axis param", 32'h2a, rv);
    host(8'h23, 8'h08, 8'h00, 32'h0);
    host(8'h0a, 8'h08, 8'h00, 32'h0);
    cmp32("module param", 32'h2a, rv);
    host(8'h27, 8'h03, 8'h00, 32'h0);
    host(8'h1f, 8'h03, 8'h00, 32'h0);
    cmp32("coordinate", 32'h2a, rv);
    foreach (bad[i]) begin
      host(bad[i], 8'h00, 8'h00, 32'h0);
      cmp32("refused ok", 32'h0, {31'h0, rok});
    end
    rdc(8'h08, 32'h2a);
    rdc(8'h0c, 32'h15);
    wr(8'h00, 32'h1);
    poll(1'b0, 8'h10, 32'h4);
    // Second event lands while the first handler still runs.
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      irq_evt[0] <= 1'b1;
      @(posedge clk);
      irq_evt[0] <= 1'b0;
    end
    poll(1'b1, 8'h09, 32'h2);
    poll(1'b0, 8'h10, 32'h4);
    rdc(8'h08, 32'h11);
    rdc(8'h04, 32'h4);
    host(8'h06, 8'h04, 8'h01, 32'h0);
    rdc(8'h08, 32'h11);
    // Masked source must stay pending without running its handler.
    host(8'h1a, 8'h00, 8'h00, 32'h0);
    @(posedge clk);
    irq_evt[0] <= 1'b1;
    @(posedge clk);
    irq_evt[0] <= 1'b0;
    repeat (3) host(8'h0a, 8'h09, 8'h00, 32'h0);
    cmp32("handler runs", 32'h2, rv);
    rdc(8'h14, 32'h1);
    end_of_test();
  end
endmodule
